// *** verilog/hrs_pkg.sv ***
// Package of constants and carriers for the hub reset sequencer
package hrs_pkg;
  // ==========================================================
  // Register map (byte offsets in the root port config space)
  localparam logic [7:0] HRS_OFF_BRIDGE_CTL  = 8'h3e;
  localparam logic [7:0] HRS_OFF_LINK_STATUS = 8'h47;
  localparam int         HRS_BIT_SEC_RESET   = 6;
  localparam int         HRS_BIT_LINK_ACTIVE = 1;
  localparam logic [15:0] HRS_BRIDGE_CTL_RST = 16'h0000;
  // Trigger register of our own for config-initiated resets
  localparam logic [7:0] HRS_OFF_RESET_TRIG  = 8'h40;
  localparam int         HRS_BIT_TRIG_HARD   = 0;
  localparam int         HRS_BIT_TRIG_CPU    = 1;
  // Sticky error status register of our own
  localparam logic [7:0] HRS_OFF_ERR_STATUS  = 8'h44;
  localparam logic [7:0] HRS_ERR_STATUS_RST  = 8'h00;
  localparam logic [7:0] HRS_PORT_ENABLE_RST = 8'h00;
  localparam logic [7:0] HRS_OFF_PORT_ENABLE = 8'h48;
  // ==========================================================
  // Timing
  localparam int HRS_CLK_HZ         = 50_000_000;
  localparam int HRS_CPU_DELAY_US   = 1000;
  localparam int HRS_CPU_DELAY_CYC  = HRS_CPU_DELAY_US * (HRS_CLK_HZ / 1_000_000);
  localparam int HRS_CORE_MIN_HCLK  = 4;
  localparam int HRS_CORE_MAX_HCLK  = 6;
  localparam int HRS_CORE_DELAY_CYC = 5;
  localparam int HRS_SYNC_STAGES    = 3;
  localparam int HRS_CPU_PULSE_CYC  = 16;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [15:0] wdata;
  } hrs_cfg_req_type;

  typedef enum logic [2:0] {
    HRS_ST_POWER_ON = 3'b000,
    HRS_ST_HARD     = 3'b001,
    HRS_ST_CORE_WT  = 3'b010,
    HRS_ST_CPU_WT   = 3'b011,
    HRS_ST_HANDSHK  = 3'b100,
    HRS_ST_RUN      = 3'b101,
    HRS_ST_CPU_ONLY = 3'b110
  } hrs_state_type;
endpackage

// *** verilog/hrs_sync.sv ***
// Multi-stage level synchroniser
`timescale 1ns/1ps
module hrs_sync
  import hrs_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Level in and out
  input  wire logic async_in,
  output logic      sync_out
);
  // ==========================================================
  // Shift chain; only the last stage is read outside
  logic [HRS_SYNC_STAGES-1:0] chain;

  // Sample the asynchronous level
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      chain <= '0;
    else
      chain <= {chain[HRS_SYNC_STAGES-2:0], async_in};
  end

  assign sync_out = chain[HRS_SYNC_STAGES-1];
endmodule // hrs_sync

// *** verilog/hrs_sequencer.sv ***
// Reset sequencer of the memory-and-I/O hub
`timescale 1ns/1ps
module hrs_sequencer
  import hrs_pkg::*;
#(
  parameter int CPU_DELAY_CYC = HRS_CPU_DELAY_CYC
)
(
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            sys_rst,
  // Platform reset pins
  input  wire logic            power_good_in,
  input  wire logic            hard_reset_in_n,
  input  wire logic            bus_init_n,
  // Configuration access
  input  wire hrs_pkg::hrs_cfg_req_type cfg_req,
  output logic [15:0]          cfg_rdata,
  output logic                 cfg_rvalid,
  // Hub handshake
  input  wire logic            hub_handshake_ack,
  output logic                 hub_handshake_req,
  // Processor and internal resets
  output logic                 processor_reset_out_n,
  output logic                 core_reset,
  output logic                 bus_state_clear,
  output logic                 refresh_enable,
  // Root port link control
  input  wire logic            link_up,
  output logic                 link_train_enable,
  output logic                 link_hot_reset
);
  // ==========================================================
  // Declarations
  logic          pg_sync;
  logic          hr_sync;
  logic          bi_sync;
  logic          hr_prev;
  hrs_state_type state;
  logic [19:0]   timer;
  logic [15:0]   bridge_ctl;
  logic [7:0]    err_status;
  logic [7:0]    port_enable;
  logic [7:0]    in_order_queue;
  logic          trig_cpu;
  logic          hard_active;
  logic          link_active;
  logic          soft_hard;

  // ==========================================================
  // Input synchronisers
  hrs_sync u_pg_sync (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .async_in (power_good_in),
    .sync_out (pg_sync)
  );
  hrs_sync u_hr_sync (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .async_in (hard_reset_in_n),
    .sync_out (hr_sync)
  );
  hrs_sync u_bi_sync (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .async_in (bus_init_n),
    .sync_out (bi_sync)
  );

  // Hard reset condition: pin low with power good, or config trigger
  assign soft_hard   = cfg_req.write && cfg_req.addr == HRS_OFF_RESET_TRIG
                       && cfg_req.wdata[HRS_BIT_TRIG_HARD];
  assign hard_active = pg_sync && !hr_sync;

  // ==========================================================
  // Sequencing state machine
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || !pg_sync)
    begin
      state <= HRS_ST_POWER_ON;
      timer <= '0;
    end
    else if (hard_active || soft_hard)
    begin
      state <= HRS_ST_HARD;
      timer <= '0;
    end
    else
    begin
      case (state)
        HRS_ST_POWER_ON, HRS_ST_HARD:
        begin
          state <= HRS_ST_CORE_WT;
          timer <= 20'd1;
        end
        HRS_ST_CORE_WT:
        begin
          timer <= timer + 20'd1;
          if (timer == 20'(HRS_CORE_DELAY_CYC - 1))
            state <= HRS_ST_CPU_WT;
        end
        HRS_ST_CPU_WT:
        begin
          timer <= timer + 20'd1;
          if (timer >= 20'(CPU_DELAY_CYC - 1))
            state <= HRS_ST_HANDSHK;
        end
        HRS_ST_HANDSHK:
        begin
          if (hub_handshake_ack)
            state <= HRS_ST_RUN;
        end
        HRS_ST_RUN:
        begin
          if (trig_cpu)
          begin
            state <= HRS_ST_CPU_ONLY;
            timer <= '0;
          end
        end
        HRS_ST_CPU_ONLY:
        begin
          timer <= timer + 20'd1;
          if (timer == 20'(HRS_CPU_PULSE_CYC - 1))
            state <= HRS_ST_RUN;
        end
        default:
          state <= HRS_ST_POWER_ON;
      endcase
    end
  end

  // ==========================================================
  // Reset outputs, all registered
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || !pg_sync)
    begin
      processor_reset_out_n <= 1'b0;
      core_reset            <= 1'b1;
      hub_handshake_req     <= 1'b0;
    end
    else
    begin
      processor_reset_out_n <= !hard_active && !soft_hard
                               && state == HRS_ST_RUN && !trig_cpu;
      core_reset            <= hard_active || soft_hard || state == HRS_ST_POWER_ON
                               || state == HRS_ST_HARD
                               || (state == HRS_ST_CORE_WT
                                   && timer != 20'(HRS_CORE_DELAY_CYC - 1));
      hub_handshake_req     <= state == HRS_ST_HANDSHK && !hub_handshake_ack;
    end
  end

  // ==========================================================
  // Bus-init handling: clear queue and trackers, keep refresh
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || core_reset)
    begin
      bus_state_clear <= 1'b1;
      in_order_queue  <= '0;
      refresh_enable  <= 1'b0;
    end
    else
    begin
      bus_state_clear <= !bi_sync;
      in_order_queue  <= !bi_sync ? '0 : in_order_queue;
      refresh_enable  <= 1'b1;
    end
  end

  // ==========================================================
  // Sticky error status: cleared by sys_rst, power-good loss or a write of ones, not by hard reset
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || !pg_sync)
      err_status <= HRS_ERR_STATUS_RST;
    else if (cfg_req.write && cfg_req.addr == HRS_OFF_ERR_STATUS)
      err_status <= (err_status & ~cfg_req.wdata[7:0])
                    | {7'h00, link_active && !link_up};  // Set wins over clear
    else if (link_active && !link_up)
      err_status[0] <= 1'b1;  // Link dropped
  end

  // ==========================================================
  // Non-sticky config registers; bus-init leaves them alone
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || core_reset)
    begin
      bridge_ctl  <= HRS_BRIDGE_CTL_RST;
      port_enable <= HRS_PORT_ENABLE_RST;
      trig_cpu    <= 1'b0;
    end
    else
    begin
      trig_cpu  <= cfg_req.write && cfg_req.addr == HRS_OFF_RESET_TRIG
                   && cfg_req.wdata[HRS_BIT_TRIG_CPU];
      if (cfg_req.write && cfg_req.addr == HRS_OFF_BRIDGE_CTL)
        bridge_ctl <= cfg_req.wdata;
      if (cfg_req.write && cfg_req.addr == HRS_OFF_PORT_ENABLE)
        port_enable <= cfg_req.wdata[7:0];
    end
  end

  // ==========================================================
  // Root port link control
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || core_reset)
    begin
      link_train_enable <= 1'b0;
      link_hot_reset    <= 1'b0;
      link_active       <= 1'b0;
    end
    else
    begin
      link_train_enable <= pg_sync && port_enable[0]
                           && !bridge_ctl[HRS_BIT_SEC_RESET];
      link_hot_reset    <= bridge_ctl[HRS_BIT_SEC_RESET];
      link_active       <= link_up && !bridge_ctl[HRS_BIT_SEC_RESET]
                           && link_train_enable;
    end
  end

  // ==========================================================
  // Register read port
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cfg_rdata  <= '0;
      cfg_rvalid <= 1'b0;
    end
    else
    begin
      cfg_rvalid <= cfg_req.read;
      case (cfg_req.addr)
        HRS_OFF_BRIDGE_CTL:  cfg_rdata <= bridge_ctl;
        HRS_OFF_LINK_STATUS: cfg_rdata <= {14'h0000, link_active, 1'b0};
        HRS_OFF_ERR_STATUS:  cfg_rdata <= {8'h00, err_status};
        HRS_OFF_PORT_ENABLE: cfg_rdata <= {8'h00, port_enable};
        default:             cfg_rdata <= 16'h0000;
      endcase
    end
  end

  // ==========================================================
  // Checks
  sequence input_release_s;
    $rose(hr_sync) && pg_sync && !soft_hard;
  endsequence

  core_release_a: assert property (@(posedge sys_clk) disable iff (sys_rst || !pg_sync)
    input_release_s ##1 !hard_active [*6] |-> !core_reset)
    else $error("core reset not released within six clocks");

  cpu_held_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    hard_active |=> !processor_reset_out_n)
    else $error("processor reset released during hard reset");

  pg_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !pg_sync |=> state == HRS_ST_POWER_ON && !processor_reset_out_n)
    else $error("not held in power-on reset");

  train_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    link_train_enable |-> $past(pg_sync && !core_reset && port_enable[0]))
    else $error("link training without enable conditions");

  link_status_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    link_active |-> $past(link_up) && !$past(bridge_ctl[HRS_BIT_SEC_RESET]))
    else $error("link active shown while link not up");

  hot_reset_a: assert property (@(posedge sys_clk) disable iff (sys_rst || core_reset)
    bridge_ctl[HRS_BIT_SEC_RESET] |=> link_hot_reset && !link_active)
    else $error("targeted reset not driven downstream");

  sticky_keep_a: assert property (@(posedge sys_clk) disable iff (sys_rst || !pg_sync)
    $rose(core_reset) |=> err_status == $past(err_status) || err_status[0])
    else $error("sticky status lost on hard reset");

  refresh_on_a: assert property (@(posedge sys_clk) disable iff (sys_rst || core_reset)
    !bi_sync && refresh_enable |=> refresh_enable && bus_state_clear)
    else $error("refresh stopped during bus init");
endmodule // hrs_sequencer

// *** test/hrs_partner.sv ***
// Model of the I/O hub handshake and the downstream link partner
`timescale 1ns/1ps
module hrs_partner
#(
  parameter int ACK_DLY   = 3,
  parameter int TRAIN_DLY = 10
)
(
  // Clock
  input  wire logic sys_clk,
  // Hub handshake
  input  wire logic hub_handshake_req,
  output logic      hub_handshake_ack = 1'b0,
  // Link
  input  wire logic link_train_enable,
  input  wire logic link_hot_reset,
  input  wire logic drop_link,
  output logic      link_up = 1'b0
);
  int ack_cnt = 0;
  int trn_cnt = 0;

  // ==========================================================
  // Ack comes some cycles after the request and holds while it stands
  always @(posedge sys_clk)
  begin
    ack_cnt <= hub_handshake_req ? ack_cnt + 1 : 0;
    hub_handshake_ack <= hub_handshake_req && (ack_cnt >= ACK_DLY);
  end

  // Link trains only while enabled and out of hot reset; drops at once
  // A drop request models the downstream side losing the link by itself
  always @(posedge sys_clk)
  begin
    trn_cnt <= (link_train_enable && !link_hot_reset && !drop_link) ? trn_cnt + 1 : 0;
    link_up <= (trn_cnt >= TRAIN_DLY) && !drop_link;
  end
endmodule // hrs_partner

// *** test/hub_reset_sequencer_bench.sv ***
// Self-checking bench for the hub reset sequencer
`timescale 1ns/1ps
module hub_reset_sequencer_bench;
  import hrs_pkg::*;
  localparam int CPU_DL = 20;
  logic            sys_clk = 1'b0;
  logic            sys_rst = 1'b1;
  logic            power_good_in = 1'b0;
  logic            hard_reset_in_n = 1'b0;
  logic            bus_init_n = 1'b1;
  logic            drop_link = 1'b0;
  hrs_cfg_req_type cfg_req = '0;
  logic [15:0]     cfg_rdata;
  logic            cfg_rvalid, hub_handshake_ack, hub_handshake_req;
  logic            processor_reset_out_n, core_reset, bus_state_clear;
  logic            refresh_enable, link_up, link_train_enable, link_hot_reset;
  logic [15:0]     d;
  int              bad_count = 0;
  int              checked = 0;
  int              cyc = 0;

  // ==========================================================
  // Design and partner
  hrs_sequencer #(.CPU_DELAY_CYC(CPU_DL)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .power_good_in(power_good_in), .hard_reset_in_n(hard_reset_in_n),
    .bus_init_n(bus_init_n), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .hub_handshake_ack(hub_handshake_ack),
    .hub_handshake_req(hub_handshake_req), .processor_reset_out_n(processor_reset_out_n),
    .core_reset(core_reset), .bus_state_clear(bus_state_clear),
    .refresh_enable(refresh_enable), .link_up(link_up),
    .link_train_enable(link_train_enable), .link_hot_reset(link_hot_reset));
  hrs_partner far_end (.sys_clk(sys_clk), .hub_handshake_req(hub_handshake_req),
    .hub_handshake_ack(hub_handshake_ack), .link_train_enable(link_train_enable),
    .link_hot_reset(link_hot_reset), .drop_link(drop_link), .link_up(link_up));

  // ==========================================================
  // Clock and cycle ceiling
  initial
  begin
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      close_out();
    end
  end

  // ==========================================================
  // Helpers
  task automatic close_out();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      $display("MISMATCH %s exp %h got %h", n, e, g);
      bad_count++;
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(negedge sys_clk);
    cfg_req = '{1'b1, 1'b0, a, v};
    @(negedge sys_clk);
    cfg_req = '0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge sys_clk);
    cfg_req = '{1'b0, 1'b1, a, 16'h0000};
    @(negedge sys_clk);
    cfg_req = '0;
    chk("rvalid", 16'h0001, {15'h0, cfg_rvalid});
    d = cfg_rdata;
  endtask
  // Releases the hard reset pin and times core and processor release
  task automatic release_hr();
    int n;
    int m;
    logic saw_req;
    n = 0;
    m = 0;
    saw_req = 1'b0;
    hard_reset_in_n = 1'b1;
    while (core_reset !== 1'b0 && n < 50)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk("core_win", 16'h0001, {15'h0, n >= HRS_SYNC_STAGES + HRS_CORE_MIN_HCLK
      && n <= HRS_SYNC_STAGES + HRS_CORE_MAX_HCLK});
    chk("cpu_held", 16'h0000, {15'h0, processor_reset_out_n});
    while (processor_reset_out_n !== 1'b1 && m < 200)
    begin
      @(negedge sys_clk);
      saw_req |= (hub_handshake_req === 1'b1);
      m++;
    end
    chk("cpu_up", 16'h0001, {15'h0, processor_reset_out_n});
    chk("cpu_dly", 16'h0001, {15'h0, n + m >= CPU_DL + HRS_SYNC_STAGES});
    chk("hs_req", 16'h0001, {15'h0, saw_req});
    chk("refresh", 16'h0001, {15'h0, refresh_enable});
  endtask
  task automatic wait_link();
    for (int i = 0; i < 60 && link_up !== 1'b1; i++) @(negedge sys_clk);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_power_on();
    power_good_in = 1'b1;
    idle(10);
    chk("cpu_rst", 16'h0000, {15'h0, processor_reset_out_n});
    chk("core_on", 16'h0001, {15'h0, core_reset});
    release_hr();
    rd(8'h10);
    chk("unmapped", 16'h0000, d);
    rd(HRS_OFF_BRIDGE_CTL);
    chk("bctl_rst", HRS_BRIDGE_CTL_RST, d);
  endtask
  task automatic t_link();
    chk("no_train", 16'h0000, {15'h0, link_train_enable});
    wr(HRS_OFF_PORT_ENABLE, 16'h0001);
    idle(2);
    chk("train", 16'h0001, {15'h0, link_train_enable});
    wait_link();
    rd(HRS_OFF_LINK_STATUS);
    chk("lnk_act", 16'h0002, d & 16'h0002);
    wr(HRS_OFF_BRIDGE_CTL, 16'h0040);
    idle(1);
    chk("hot_rst", 16'h0001, {15'h0, link_hot_reset});
    idle(3);
    rd(HRS_OFF_LINK_STATUS);
    chk("lnk_down", 16'h0000, d & 16'h0002);
    wr(HRS_OFF_BRIDGE_CTL, 16'h0000);
    rd(HRS_OFF_LINK_STATUS);
    chk("lnk_wait", 16'h0000, d & 16'h0002);
    wait_link();
    rd(HRS_OFF_LINK_STATUS);
    chk("lnk_back", 16'h0002, d & 16'h0002);
    // Downstream drops the link on its own: sticky error bit records it
    drop_link = 1'b1;
    idle(3);
    drop_link = 1'b0;
    rd(HRS_OFF_ERR_STATUS);
    chk("lnk_err", 16'h0001, d & 16'h0001);
    wait_link();
  endtask
  task automatic t_bus_init();
    bus_init_n = 1'b0;
    idle(6);
    chk("bclr", 16'h0001, {15'h0, bus_state_clear});
    chk("bi_ref", 16'h0001, {15'h0, refresh_enable});
    chk("bi_link", 16'h0001, {15'h0, link_up & link_train_enable});
    bus_init_n = 1'b1;
    idle(6);
    chk("bclr_off", 16'h0000, {15'h0, bus_state_clear});
    rd(HRS_OFF_PORT_ENABLE);
    chk("bi_cfg", 16'h0001, d & 16'h0001);
  endtask
  task automatic t_cpu_only();
    logic seen;
    seen = 1'b0;
    wr(HRS_OFF_RESET_TRIG, 16'h0002);
    for (int i = 0; i < HRS_CPU_PULSE_CYC + 10; i++)
    begin
      seen |= (processor_reset_out_n === 1'b0);
      chk("co_core", 16'h0000, {15'h0, core_reset});
      @(negedge sys_clk);
    end
    chk("co_pulse", 16'h0001, {15'h0, seen & processor_reset_out_n});
    rd(HRS_OFF_PORT_ENABLE);
    chk("co_cfg", 16'h0001, d & 16'h0001);
  endtask
  task automatic t_hard();
    hard_reset_in_n = 1'b0;
    idle(6);
    chk("hr_cpu", 16'h0000, {15'h0, processor_reset_out_n});
    chk("hr_link", 16'h0000, {15'h0, link_train_enable});
    chk("hr_core", 16'h0001, {15'h0, core_reset});
    release_hr();
    rd(HRS_OFF_ERR_STATUS);
    chk("sticky", 16'h0001, d & 16'h0001);
    rd(HRS_OFF_PORT_ENABLE);
    chk("nonstk", 16'h0000, d);
    wr(HRS_OFF_RESET_TRIG, 16'h0001);
    chk("trig_hr", 16'h0001, {15'h0, core_reset});
    for (int i = 0; i < 200 && processor_reset_out_n !== 1'b1; i++) @(negedge sys_clk);
    chk("trig_end", 16'h0001, {15'h0, processor_reset_out_n});
  endtask
  task automatic t_power_drop();
    power_good_in = 1'b0;
    hard_reset_in_n = 1'b0;
    idle(6);
    chk("pg_core", 16'h0001, {15'h0, core_reset});
    chk("pg_cpu", 16'h0000, {15'h0, processor_reset_out_n});
    power_good_in = 1'b1;
    idle(10);
    release_hr();
    rd(HRS_OFF_ERR_STATUS);
    chk("pg_stk", HRS_ERR_STATUS_RST, d);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    idle(5);
    sys_rst = 1'b0;
    t_power_on();
    t_link();
    t_bus_init();
    t_cpu_only();
    t_hard();
    t_power_drop();
    close_out();
  end
endmodule // hub_reset_sequencer_bench
